// ==== hw/dma_cfg_pkg.sv ====
// Contract
// RULE1: ten-bit count, minus-one encoded, bits 25-16
// RULE2: bytes moved equal (count+1) times width
// RULE3: count field counts down while moving
// RULE4: destination step from bits 15-14
// RULE5: source step from bits 13-12
// RULE6: bits 9-8 pick byte, halfword or word width
// RULE7: width 10b is word; 11b never used
// RULE8: reload next descriptor after full count
// RULE9: reserved bits undefined; fields reset zero
// RULE10: exhaustion raises flag A or B
// RULE11: drop-trigger bit clears trigger on exhaustion
// RULE12: software trigger write sets trigger at once
// RULE13: exhausted after transfer at count zero
package dma_cfg_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [11:0] OFS_XFER_CFG = 12'h458;
	localparam logic [11:0] OFS_SRC_ADDR = 12'h500;
	localparam logic [11:0] OFS_DST_ADDR = 12'h504;
	localparam logic [11:0] OFS_NEXT_CFG = 12'h508;
	localparam logic [11:0] OFS_NEXT_SRC = 12'h50C;
	localparam logic [11:0] OFS_NEXT_DST = 12'h510;
	localparam logic [11:0] OFS_STATUS   = 12'h514;
	localparam logic [11:0] OFS_CLEAR    = 12'h518;
	localparam logic [11:0] OFS_IRQ_EN   = 12'h51C;
	localparam logic [11:0] OFS_CHAN_CTL = 12'h520;

	// ------------------------------------------------------------
	// field positions of the transfer configuration word
	// ------------------------------------------------------------
	localparam int POS_COUNT   = 16;
	localparam int POS_DSTSTEP = 14;
	localparam int POS_SRCSTEP = 12;
	localparam int POS_WIDTH   = 8;
	localparam int POS_FLAG_B  = 5;
	localparam int POS_FLAG_A  = 4;
	localparam int POS_DROP    = 3;
	localparam int POS_SOFTWARE_TRIGGER  = 2;
	localparam int POS_RELOAD  = 1;
	localparam int POS_VALID   = 0;
	localparam int COUNT_W     = 10;

	// status, clear and enable bits
	localparam int ST_FLAG_A = 0;
	localparam int ST_FLAG_B = 1;
	localparam int ST_WERR   = 2;
	localparam int ST_W      = 3;

	// channel control bits
	localparam int CTL_ENABLE = 0;
	localparam int CTL_HWTRIG = 1;

	// width encodings
	localparam logic [1:0] WIDTH_BYTE = 2'h0;
	localparam logic [1:0] WIDTH_HALF = 2'h1;
	localparam logic [1:0] WIDTH_WORD = 2'h2;
	localparam logic [1:0] WIDTH_RSVD = 2'h3;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_READ  = 3'b010,
		ST_WRITE = 3'b100
	} eng_state_t;

	typedef struct packed {
		logic [COUNT_W-1:0] count;
		logic [1:0]         dst_step;
		logic [1:0]         src_step;
		logic [1:0]         width;
		logic               flag_b;
		logic               flag_a;
		logic               drop;
		logic               reload;
		logic               valid;
	} xfer_cfg_t;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [1:0]  size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} mem_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] rdata;
	} mem_rsp_t;

	typedef struct packed {
		eng_state_t      fsm;
		xfer_cfg_t       cfg;
		xfer_cfg_t       next_cfg;
		logic [31:0]     src;
		logic [31:0]     dst;
		logic [31:0]     next_src;
		logic [31:0]     next_dst;
		logic            trigger;
		logic [ST_W-1:0] status;
		logic [ST_W-1:0] irq_en;
		logic [1:0]      ctl;
		logic [2:0]      hw_sync;
		mem_req_t        mem;
		logic            flag_a;
		logic            flag_b;
		logic            irq;
		logic            pready;
		logic            pslverr;
		logic [31:0]     prdata;
	} chan_state_t;

endpackage

// ==== hw/addr_stepper.sv ====
`timescale 1ns/10ps
module addr_stepper
	import dma_cfg_pkg::*;
#(
	parameter int AW = 32
) (
	input  wire logic [AW-1:0] addr,
	input  wire logic [1:0]    step,
	input  wire logic [1:0]    width,
	output logic      [AW-1:0] next_addr
);
	logic [AW-1:0] unit;
	logic [AW-1:0] inc;

	// ------------------------------------------------------------
	// step of none, one, two or four widths
	// ------------------------------------------------------------
	always_comb begin
		unit = AW'(1) << width;
		case (step)
			2'h0: inc = '0;
			2'h1: inc = unit;
			2'h2: inc = unit << 1;
			default: inc = unit << 2;
		endcase
		next_addr = addr + inc;
	end
endmodule // addr_stepper

// ==== hw/dma_channel.sv ====
// Chosen here: the APB slave port.
`timescale 1ns/10ps
module dma_channel
	import dma_cfg_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        hw_trigger,
	output mem_req_t         mem_req,
	input  wire mem_rsp_t    mem_rsp,
	output logic             channel_flag_a,
	output logic             channel_flag_b,
	output logic             irq
);
	chan_state_t s_reg;
	chan_state_t s_next;
	logic [31:0] src_stepped;
	logic [31:0] dst_stepped;
	logic [31:0] rd_word;
	logic        acc;
	logic        wr_hit;
	logic        mapped;
	logic        hw_edge;
	logic        done_xfer;
	logic        exhausted;
	logic        start_ok;

	// ------------------------------------------------------------
	// address steppers
	// ------------------------------------------------------------
	addr_stepper #(
		.AW(32)
	) u_src_step (
		.addr     (s_reg.src),
		.step     (s_reg.cfg.src_step),
		.width    (s_reg.cfg.width),
		.next_addr(src_stepped)
	); // [RULE5]

	addr_stepper #(
		.AW(32)
	) u_dst_step (
		.addr     (s_reg.dst),
		.step     (s_reg.cfg.dst_step),
		.width    (s_reg.cfg.width),
		.next_addr(dst_stepped)
	); // [RULE4]

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] pack_cfg(
		input xfer_cfg_t c,
		input logic      trig
	);
		logic [31:0] w;
		w = 32'h0; // [RULE9]
		w[POS_COUNT +: COUNT_W] = c.count;
		w[POS_DSTSTEP +: 2] = c.dst_step;
		w[POS_SRCSTEP +: 2] = c.src_step;
		w[POS_WIDTH +: 2] = c.width;
		w[POS_FLAG_B] = c.flag_b;
		w[POS_FLAG_A] = c.flag_a;
		w[POS_DROP] = c.drop;
		w[POS_SOFTWARE_TRIGGER] = trig;
		w[POS_RELOAD] = c.reload;
		w[POS_VALID] = c.valid;
		return w;
	endfunction

	function automatic xfer_cfg_t unpack_cfg(input logic [31:0] w);
		xfer_cfg_t c;
		c.count = w[POS_COUNT +: COUNT_W]; // [RULE1]
		c.dst_step = w[POS_DSTSTEP +: 2];
		c.src_step = w[POS_SRCSTEP +: 2];
		c.width = w[POS_WIDTH +: 2]; // [RULE6]
		c.flag_b = w[POS_FLAG_B];
		c.flag_a = w[POS_FLAG_A];
		c.drop = w[POS_DROP];
		c.reload = w[POS_RELOAD];
		c.valid = w[POS_VALID];
		return c;
	endfunction

	// ------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------
	always_comb begin
		rd_word = 32'h0;
		mapped = 1'b1;
		case (paddr)
			OFS_XFER_CFG: rd_word = pack_cfg(s_reg.cfg, s_reg.trigger);
			OFS_SRC_ADDR: rd_word = s_reg.src;
			OFS_DST_ADDR: rd_word = s_reg.dst;
			OFS_NEXT_CFG: rd_word = pack_cfg(s_reg.next_cfg, 1'b0);
			OFS_NEXT_SRC: rd_word = s_reg.next_src;
			OFS_NEXT_DST: rd_word = s_reg.next_dst;
			OFS_STATUS: rd_word = {29'h0, s_reg.status};
			OFS_CLEAR: rd_word = 32'h0;
			OFS_IRQ_EN: rd_word = {29'h0, s_reg.irq_en};
			OFS_CHAN_CTL: rd_word = {30'h0, s_reg.ctl};
			default: mapped = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		logic [ST_W-1:0] ev;
		ev = '0;
		s_next = s_reg;
		acc = psel && penable;
		wr_hit = acc && s_reg.pready && pwrite;
		done_xfer = 1'b0;
		exhausted = 1'b0;

		// bus answer: one wait cycle, then ready
		s_next.pready = acc && !s_reg.pready;
		s_next.pslverr = acc && !s_reg.pready && !mapped;
		if (acc && !s_reg.pready && !pwrite) begin
			s_next.prdata = rd_word;
		end

		// hardware trigger synchroniser and edge
		s_next.hw_sync = {s_reg.hw_sync[1:0], hw_trigger};
		hw_edge = s_reg.hw_sync[1] && !s_reg.hw_sync[2];

		// engine
		start_ok = s_reg.cfg.valid && s_reg.trigger
			&& s_reg.ctl[CTL_ENABLE];
		case (s_reg.fsm)
			ST_IDLE: begin
				if (start_ok) begin
					if (s_reg.cfg.width == WIDTH_RSVD) begin
						ev[ST_WERR] = 1'b1; // [RULE7]
						s_next.cfg.valid = 1'b0;
					end else begin
						s_next.fsm = ST_READ;
						s_next.mem.valid = 1'b1;
						s_next.mem.write = 1'b0;
						s_next.mem.addr = s_reg.src;
						s_next.mem.size = s_reg.cfg.width; // [RULE2]
					end
				end
			end
			ST_READ: begin
				if (mem_rsp.ack) begin
					s_next.fsm = ST_WRITE;
					s_next.mem.write = 1'b1;
					s_next.mem.addr = s_reg.dst;
					s_next.mem.wdata = mem_rsp.rdata;
				end
			end
			ST_WRITE: begin
				if (mem_rsp.ack) begin
					done_xfer = 1'b1;
					s_next.fsm = ST_IDLE;
					s_next.mem.valid = 1'b0;
					s_next.mem.write = 1'b0;
				end
			end
			default: begin
				s_next.fsm = ST_IDLE;
				s_next.mem.valid = 1'b0;
			end
		endcase

		if (done_xfer) begin
			s_next.src = src_stepped; // [RULE5]
			s_next.dst = dst_stepped; // [RULE4]
			if (s_reg.cfg.count == '0) begin
				exhausted = 1'b1; // [RULE13]
			end else begin
				s_next.cfg.count = s_reg.cfg.count - 1'b1; // [RULE3]
			end
		end

		if (exhausted) begin
			ev[ST_FLAG_A] = s_reg.cfg.flag_a; // [RULE10]
			ev[ST_FLAG_B] = s_reg.cfg.flag_b; // [RULE10]
			if (s_reg.cfg.drop) begin
				s_next.trigger = 1'b0; // [RULE11]
			end
			if (s_reg.cfg.reload) begin
				s_next.cfg = s_reg.next_cfg; // [RULE8]
				s_next.src = s_reg.next_src;
				s_next.dst = s_reg.next_dst;
			end else begin
				s_next.cfg.valid = 1'b0;
			end
		end

		// a trigger edge beats a same-cycle drop on exhaustion
		if (hw_edge && s_reg.ctl[CTL_HWTRIG]) begin
			s_next.trigger = 1'b1; // [RULE12]
		end

		// register writes
		if (wr_hit) begin
			case (paddr)
				OFS_XFER_CFG: begin
					s_next.cfg = unpack_cfg(pwdata);
					if (pwdata[POS_SOFTWARE_TRIGGER]) begin
						s_next.trigger = 1'b1; // [RULE12]
					end
				end
				OFS_SRC_ADDR: s_next.src = pwdata;
				OFS_DST_ADDR: s_next.dst = pwdata;
				OFS_NEXT_CFG: s_next.next_cfg = unpack_cfg(pwdata);
				OFS_NEXT_SRC: s_next.next_src = pwdata;
				OFS_NEXT_DST: s_next.next_dst = pwdata;
				OFS_IRQ_EN: s_next.irq_en = pwdata[ST_W-1:0];
				OFS_CHAN_CTL: s_next.ctl = pwdata[1:0];
				default: ;
			endcase
		end

		// sticky status: a new event beats a clear
		if (wr_hit && paddr == OFS_CLEAR) begin
			s_next.status = s_reg.status & ~pwdata[ST_W-1:0];
		end
		s_next.status = s_next.status | ev;

		s_next.flag_a = s_next.status[ST_FLAG_A];
		s_next.flag_b = s_next.status[ST_FLAG_B];
		s_next.irq = |(s_next.status & s_next.irq_en);
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_reg <= '0; // [RULE9]
			s_reg.fsm <= ST_IDLE;
		end else begin
			s_reg <= s_next;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign prdata = s_reg.prdata;
	assign pready = s_reg.pready;
	assign pslverr = s_reg.pslverr;
	assign mem_req = s_reg.mem;
	assign channel_flag_a = s_reg.flag_a;
	assign channel_flag_b = s_reg.flag_b;
	assign irq = s_reg.irq;
endmodule // dma_channel

// ==== tb/dma_channel_properties.sv ====
`timescale 1ns/10ps
module dma_channel_properties
	import dma_cfg_pkg::*;
(
	input wire logic     clk,
	input wire logic     reset_n,
	input wire logic     psel,
	input wire logic     penable,
	input wire logic     pready,
	input wire mem_req_t mem_req,
	input wire mem_rsp_t mem_rsp,
	input wire logic     channel_flag_a,
	input wire logic     channel_flag_b
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	logic rd_ack, wr_ack;
	assign rd_ack = mem_req.valid && !mem_req.write && mem_rsp.ack;
	assign wr_ack = mem_req.valid && mem_req.write && mem_rsp.ack;
	property p_access;
		psel && penable && !pready |=> pready;
	endproperty
	a_access: assert property (p_access) else $error("late pready");
	property p_rdy_pulse;
		pready |=> !pready;
	endproperty
	a_rdy_pulse: assert property (p_rdy_pulse) else $error("long pready");
	property p_hold;
		mem_req.valid && !mem_rsp.ack |=> $stable(mem_req);
	endproperty
	a_hold: assert property (p_hold) else $error("request moved");
	property p_size;
		mem_req.valid |-> mem_req.size != WIDTH_RSVD;
	endproperty
	a_size: assert property (p_size) else $error("bad size");
	property p_rd_wr;
		rd_ack |=> mem_req.valid && mem_req.write
			&& mem_req.wdata[7:0] == $past(mem_rsp.rdata[7:0]);
	endproperty
	a_rd_wr: assert property (p_rd_wr) else $error("no write");
	property p_done_idle;
		wr_ack |=> !mem_req.valid;
	endproperty
	a_done_idle: assert property (p_done_idle) else $error("no gap");
	property p_flag_a;
		$rose(channel_flag_a) |-> $past(wr_ack);
	endproperty
	a_flag_a: assert property (p_flag_a) else $error("flag a");
	property p_flag_b;
		$rose(channel_flag_b) |-> $past(wr_ack);
	endproperty
	a_flag_b: assert property (p_flag_b) else $error("flag b");
endmodule // dma_channel_properties

bind dma_channel dma_channel_properties u_props (.clk(clk),
	.reset_n(reset_n), .psel(psel), .penable(penable), .pready(pready),
	.mem_req(mem_req), .mem_rsp(mem_rsp),
	.channel_flag_a(channel_flag_a), .channel_flag_b(channel_flag_b));

// ==== tb/mem_model.sv ====
`timescale 1ns/10ps
module mem_model
	import dma_cfg_pkg::*;
(
	input  wire logic     clk,
	input  wire logic     reset_n,
	input  wire logic     slow,
	input  wire mem_req_t mem_req,
	output mem_rsp_t      mem_rsp
);
	logic [31:0] wa[$];
	logic [31:0] ra[$];
	int          bytes;
	int          wcnt;
	// memory side: acks after a wait, logs addresses, stale data toggles
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			mem_rsp <= '0;
			wcnt    <= 0;
			bytes   <= 0;
		end else if (mem_req.valid && !mem_rsp.ack
			&& wcnt >= (slow ? 8 : 0)) begin
			mem_rsp.ack   <= 1'b1;
			mem_rsp.rdata <= ~mem_req.addr;
			wcnt          <= 0;
			if (mem_req.write) begin
				wa.push_back(mem_req.addr);
				bytes <= bytes + (1 << mem_req.size);
			end else begin
				ra.push_back(mem_req.addr);
			end
		end else begin
			mem_rsp.ack   <= 1'b0;
			mem_rsp.rdata <= ~mem_rsp.rdata;
			wcnt          <= mem_req.valid ? wcnt + 1 : 0;
		end
	end
endmodule // mem_model

// ==== tb/test_dma_channel.sv ====
`timescale 1ns/10ps
module test_dma_channel
	import dma_cfg_pkg::*;
;
	logic        clk, reset_n, psel, penable, pwrite, slow, se, hwt;
	logic        pready, pslverr, channel_flag_a, channel_flag_b, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	mem_req_t    mem_req;
	mem_rsp_t    mem_rsp;
	int          err_count, samples_checked, n0, b0;

	dma_channel dut (.clk(clk), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .hw_trigger(hwt), .mem_req(mem_req),
		.mem_rsp(mem_rsp), .channel_flag_a(channel_flag_a),
		.channel_flag_b(channel_flag_b), .irq(irq));
	mem_model m (.clk(clk), .reset_n(reset_n), .slow(slow),
		.mem_req(mem_req), .mem_rsp(mem_rsp));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		se = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		samples_checked++;
		if (s !== e) begin
			err_count++;
			$display("ERROR %s exp %h got %h", n, e, s);
		end
	endtask

	task wait_wr(input int k);
		while (m.wa.size() < k) @(posedge clk);
		repeat (3) @(posedge clk);
	endtask

	task close_out;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		#150000;
		err_count++;
		close_out;
	end

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		{psel, penable, pwrite, slow, hwt, reset_n} = '0;
		paddr  = '0;
		pwdata = '0;
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		apb(0, OFS_XFER_CFG, 0);
		chk("cfg reset", 0, rd & 32'h03FF_F33F);
		apb(0, 12'h7FC, 0);
		chk("unmapped", 1, {31'h0, se});
		apb(1, OFS_CHAN_CTL, 1);
		apb(1, OFS_XFER_CFG, 32'h0000_0305);
		apb(0, OFS_STATUS, 0);
		chk("width err", 4, rd);
		apb(1, OFS_CLEAR, 7);
		$display("setup test done");
		slow <= 1'b1;
		apb(1, OFS_SRC_ADDR, 32'h0000_1000);
		apb(1, OFS_DST_ADDR, 32'h0000_2000);
		apb(1, OFS_IRQ_EN, 1);
		n0 = m.wa.size();
		b0 = m.bytes;
		apb(1, OFS_XFER_CFG, 32'h0002_911D);
		wait_wr(n0 + 1);
		apb(0, OFS_XFER_CFG, 0);
		chk("count", 1, {22'h0, rd[25:16]});
		wait_wr(n0 + 3);
		for (int i = 0; i < 3; i++) begin
			chk("dst", 32'h2000 + 4 * i, m.wa[n0 + i]);
			chk("src", 32'h1000 + 2 * i, m.ra[n0 + i]);
		end
		chk("bytes", 6, m.bytes - b0);
		apb(0, OFS_XFER_CFG, 0);
		chk("valid trig", 0, rd & 5);
		chk("flag a", 1, {31'h0, channel_flag_a});
		chk("irq", 1, {31'h0, irq});
		apb(1, OFS_CLEAR, 1);
		apb(0, OFS_STATUS, 0);
		chk("status", 0, rd);
		chk("irq clr", 0, {31'h0, irq});
		$display("count test done");
		slow <= 1'b0;
		apb(1, OFS_NEXT_SRC, 32'h0000_3000);
		apb(1, OFS_NEXT_DST, 32'h0000_4000);
		apb(1, OFS_NEXT_CFG, 32'h0000_C229);
		apb(1, OFS_DST_ADDR, 32'h0000_5000);
		n0 = m.wa.size();
		b0 = m.bytes;
		apb(1, OFS_XFER_CFG, 32'h0000_0007);
		wait_wr(n0 + 2);
		chk("first", 32'h5000, m.wa[n0]);
		chk("reload", 32'h4000, m.wa[n0 + 1]);
		chk("bytes", 5, m.bytes - b0);
		chk("flag b", 1, {31'h0, channel_flag_b});
		$display("reload test done");
		apb(1, OFS_CHAN_CTL, 3);
		n0 = m.wa.size();
		apb(1, OFS_XFER_CFG, 32'h0000_0001);
		repeat (20) @(posedge clk);
		chk("no start", n0, m.wa.size());
		hwt <= 1'b1;
		wait_wr(n0 + 1);
		chk("hw start", n0 + 1, m.wa.size());
		$display("hw trigger test done");
		close_out;
	end
endmodule // test_dma_channel
